//--- verilog/aer_pkg.sv
// Package: offsets, field layouts and reset values of the error logging registers
package aer_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [11:0] AER_OFS_HDR = 12'h100;
  localparam logic [11:0] AER_OFS_UNC_STS = 12'h104;
  localparam logic [11:0] AER_OFS_UNC_MSK = 12'h108;
  localparam logic [11:0] AER_OFS_UNC_SEV = 12'h10C;
  localparam logic [11:0] AER_OFS_COR_STS = 12'h110;
  localparam logic [11:0] AER_OFS_COR_MSK = 12'h114;
  localparam logic [11:0] AER_OFS_CAP_CTL = 12'h118;
  // ==========================================================================
  // Capability header fields
  localparam int AER_NXT_LSB = 20;
  localparam int AER_NXT_W = 12;
  localparam int AER_VER_LSB = 16;
  localparam int AER_VER_W = 4;
  localparam int AER_CID_LSB = 0;
  localparam int AER_CID_W = 16;
  localparam logic [31:0] AER_HDR_RST = 32'h0000_0000;
  // ==========================================================================
  // Uncorrectable registers
  localparam logic [31:0] AER_UNC_IMPL = 32'h0037_D010;
  localparam logic [31:0] AER_UNC_MSK_RST = 32'h0000_0000;
  localparam logic [31:0] AER_UNC_SEV_RST = 32'h0006_0011;
  localparam logic [31:0] AER_UNC_SEV_FIXED = 32'h0000_0001;
  localparam int AER_UNC_CT_BIT = 14;
  // ==========================================================================
  // Correctable registers
  localparam logic [31:0] AER_COR_IMPL = 32'h0000_31C1;
  localparam logic [31:0] AER_COR_MSK_RST = 32'h0000_2000;
  localparam int AER_COR_ANF_BIT = 13;
  // ==========================================================================
  // Capabilities and control
  localparam int AER_FEP_W = 5;
  localparam logic [4:0] AER_FEP_RST = 5'h00;
endpackage

//--- verilog/aer_flag_if.sv
// Interface: set, clear and value lines of one sticky status bank
`timescale 1ns/1ps
`default_nettype none
interface aer_flag_if #(parameter int W = 32);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] val;
  modport bank (input set, input clr, output val);
  modport user (output set, output clr, input val);
endinterface
`default_nettype wire

//--- verilog/aer_w1c_bank.sv
// Sticky write-one-to-clear status bank kept through platform reset
`timescale 1ns/1ps
`default_nettype none
module aer_w1c_bank #(
  parameter int W = 32,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic clk_sys,
  input wire logic pwr_rst,
  aer_flag_if.bank f
);
  logic [W-1:0] val_reg;
  logic [W-1:0] val_next;

  // ==========================================================================
  // Set beats clear; unimplemented bits stay zero
  always_comb begin
    val_next = ((val_reg & ~f.clr) | f.set) & IMPL;
  end

  always_ff @(posedge clk_sys) begin
    if (pwr_rst) begin
      val_reg <= '0;
    end else begin
      val_reg <= val_next;
    end
  end

  assign f.val = val_reg;

  a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (pwr_rst)
    (f.set != '0) |=> ((val_reg & $past(f.set & IMPL)) == $past(f.set & IMPL)))
    else $error("set event lost against clear");
endmodule
`default_nettype wire

//--- verilog/aer_err_log.sv
// Advanced error logging register set of a root port
//
// Overview of operation
// - Next capability pointer, bits 31:20, write once, expected zero as list end.
// - Uncorrectable status survives platform reset, clears only on core power loss.
// - Sticky W1C uncorrectable flags: ACS, unsupported, malformed, overflow, unexpected, abort.
// - Completion timeout flag sets only while timeout checking is enabled, or from an advisory report at its position.
// - Sticky W1C flags for poisoned TLP and link protocol error.
// - ECRC, flow control, surprise down and training bits are read-only.
// - Set uncorrectable mask bit suppresses action for that logged error.
// - Mask and severity registers reset only by core power loss.
// - Severity bit one means fatal, zero means non-fatal.
// - Severity resets with malformed, overflow, link protocol errors fatal.
// - Training error severity bit is read-only and reads one.
// - Sticky W1C flags for replay timer expiry and replay count rollover.
// - Sticky W1C flags for bad DLLP, bad TLP and receiver error.
// - Sticky W1C flag for advisory non-fatal errors.
// - Set correctable mask bit suppresses action, aligned with status bits.
// - Advisory mask resets to one; when set, no correctable signal or uncorrectable update.
// - ECRC enable and capable bits read zero.
// - Power-sticky five-bit pointer holds position of first uncorrectable error.
`timescale 1ns/1ps
`default_nettype none
module aer_err_log
  import aer_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pwr_rst,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [ADDR_W-1:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic [31:0] unc_err_pulse,
  input wire logic cpl_timeout_en,
  input wire logic [31:0] cor_err_pulse,
  input wire logic adv_nonfatal_pulse,
  input wire logic [4:0] adv_unc_pos,
  output logic unc_fatal_evt,
  output logic unc_nonfatal_evt,
  output logic cor_err_evt
);
  // ==========================================================================
  // Storage
  logic [AER_NXT_W-1:0] next_capability_pointer_reg;
  logic [AER_VER_W-1:0] capability_version_field_reg;
  logic [AER_CID_W-1:0] capability_identifier_field_reg;
  logic hdr_written_reg;
  logic [31:0] unc_msk_reg;
  logic [31:0] unc_sev_reg;
  logic [31:0] cor_msk_reg;
  logic [AER_FEP_W-1:0] first_error_pointer_reg;
  logic [31:0] cfg_rdata_reg;
  logic cfg_rvalid_reg;
  logic unc_fatal_reg;
  logic unc_nonfatal_reg;
  logic cor_evt_reg;

  logic [31:0] unc_set;
  logic [31:0] cor_set;
  logic [31:0] unc_live;
  logic [31:0] unc_sev_view;
  logic anf_blocked;
  logic [31:0] rd_mux;

  aer_flag_if #(.W(32)) unc_if ();
  aer_flag_if #(.W(32)) cor_if ();

  // ==========================================================================
  // Status banks
  aer_w1c_bank #(.W(32), .IMPL(AER_UNC_IMPL)) u_unc_bank (
    .clk_sys(clk_sys),
    .pwr_rst(pwr_rst),
    .f(unc_if.bank)
  );

  aer_w1c_bank #(.W(32), .IMPL(AER_COR_IMPL)) u_cor_bank (
    .clk_sys(clk_sys),
    .pwr_rst(pwr_rst),
    .f(cor_if.bank)
  );

  // ==========================================================================
  // Event steering
  function automatic logic [4:0] lowest_bit(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  assign anf_blocked = cor_msk_reg[AER_COR_ANF_BIT];

  always_comb begin
    unc_set = unc_err_pulse & AER_UNC_IMPL;
    unc_set[AER_UNC_CT_BIT] = unc_err_pulse[AER_UNC_CT_BIT] & cpl_timeout_en;
    if (adv_nonfatal_pulse && !anf_blocked) begin
      unc_set = unc_set | ((32'h0000_0001 << adv_unc_pos) & AER_UNC_IMPL);
    end
  end

  always_comb begin
    cor_set = cor_err_pulse & AER_COR_IMPL;
    cor_set[AER_COR_ANF_BIT] = adv_nonfatal_pulse;
  end

  assign unc_if.set = unc_set;
  assign cor_if.set = cor_set;
  assign unc_if.clr = (cfg_wr && cfg_addr == AER_OFS_UNC_STS) ? cfg_wdata : 32'h0000_0000;
  assign cor_if.clr = (cfg_wr && cfg_addr == AER_OFS_COR_STS) ? cfg_wdata : 32'h0000_0000;

  assign unc_live = unc_set & ~unc_msk_reg;
  assign unc_sev_view = (unc_sev_reg & AER_UNC_IMPL) | AER_UNC_SEV_FIXED;

  // ==========================================================================
  // Capability header, write once
  always_ff @(posedge clk_sys) begin
    if (pwr_rst) begin
      next_capability_pointer_reg <= AER_HDR_RST[AER_NXT_LSB +: AER_NXT_W];
      capability_version_field_reg <= AER_HDR_RST[AER_VER_LSB +: AER_VER_W];
      capability_identifier_field_reg <= AER_HDR_RST[AER_CID_LSB +: AER_CID_W];
      hdr_written_reg <= 1'b0;
    end else if (cfg_wr && cfg_addr == AER_OFS_HDR && !hdr_written_reg) begin
      next_capability_pointer_reg <= cfg_wdata[AER_NXT_LSB +: AER_NXT_W];
      capability_version_field_reg <= cfg_wdata[AER_VER_LSB +: AER_VER_W];
      capability_identifier_field_reg <= cfg_wdata[AER_CID_LSB +: AER_CID_W];
      hdr_written_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Mask and severity, power sticky
  always_ff @(posedge clk_sys) begin
    if (pwr_rst) begin
      unc_msk_reg <= AER_UNC_MSK_RST;
      unc_sev_reg <= AER_UNC_SEV_RST;
      cor_msk_reg <= AER_COR_MSK_RST;
    end else if (cfg_wr) begin
      if (cfg_addr == AER_OFS_UNC_MSK) begin
        unc_msk_reg <= cfg_wdata & AER_UNC_IMPL;
      end
      if (cfg_addr == AER_OFS_UNC_SEV) begin
        unc_sev_reg <= (cfg_wdata & AER_UNC_IMPL) | AER_UNC_SEV_FIXED;
      end
      if (cfg_addr == AER_OFS_COR_MSK) begin
        cor_msk_reg <= cfg_wdata & AER_COR_IMPL;
      end
    end
  end

  // ==========================================================================
  // First error pointer
  always_ff @(posedge clk_sys) begin
    if (pwr_rst) begin
      first_error_pointer_reg <= AER_FEP_RST;
    end else if (unc_live != 32'h0000_0000 && unc_if.val == 32'h0000_0000) begin
      first_error_pointer_reg <= lowest_bit(unc_live);
    end
  end

  // ==========================================================================
  // Error signalling
  always_ff @(posedge clk_sys) begin
    if (pwr_rst || rst) begin
      unc_fatal_reg <= 1'b0;
      unc_nonfatal_reg <= 1'b0;
      cor_evt_reg <= 1'b0;
    end else begin
      unc_fatal_reg <= |(unc_live & unc_sev_view);
      unc_nonfatal_reg <= |(unc_live & ~unc_sev_view);
      cor_evt_reg <= |(cor_set & ~cor_msk_reg);
    end
  end

  // ==========================================================================
  // Configuration reads
  always_comb begin
    case (cfg_addr)
      AER_OFS_HDR: rd_mux = {next_capability_pointer_reg, capability_version_field_reg,
                             capability_identifier_field_reg};
      AER_OFS_UNC_STS: rd_mux = unc_if.val;
      AER_OFS_UNC_MSK: rd_mux = unc_msk_reg;
      AER_OFS_UNC_SEV: rd_mux = unc_sev_view;
      AER_OFS_COR_STS: rd_mux = cor_if.val;
      AER_OFS_COR_MSK: rd_mux = cor_msk_reg;
      AER_OFS_CAP_CTL: rd_mux = {27'h0000000, first_error_pointer_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (pwr_rst || rst) begin
      cfg_rdata_reg <= 32'h0000_0000;
      cfg_rvalid_reg <= 1'b0;
    end else begin
      cfg_rvalid_reg <= cfg_rd;
      cfg_rdata_reg <= cfg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign cfg_rdata = cfg_rdata_reg;
  assign cfg_rvalid = cfg_rvalid_reg;
  assign unc_fatal_evt = unc_fatal_reg;
  assign unc_nonfatal_evt = unc_nonfatal_reg;
  assign cor_err_evt = cor_evt_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (pwr_rst);

  sequence s_clean_write;
    cfg_wr && cfg_addr == AER_OFS_UNC_STS && (cfg_wdata & unc_if.val) != 0 && unc_set == 0;
  endsequence

  sequence s_cor_clean_write;
    cfg_wr && cfg_addr == AER_OFS_COR_STS && (cfg_wdata & cor_if.val) != 0 && cor_set == 0;
  endsequence

  sequence s_unc_pulse;
    cpl_timeout_en && (unc_err_pulse & AER_UNC_IMPL) != 0;
  endsequence

  sequence s_cor_pulse;
    (cor_err_pulse & AER_COR_IMPL & ~(32'h0000_0001 << AER_COR_ANF_BIT)) != 0;
  endsequence

  sequence s_hdr_locked_write;
    hdr_written_reg && cfg_wr && cfg_addr == AER_OFS_HDR;
  endsequence

  sequence s_plat_rst_quiet;
    rst && !cfg_wr;
  endsequence

  a_unc_w1c_clear: assert property (s_clean_write |=>
    (unc_if.val & $past(cfg_wdata)) == 0)
    else $error("write one did not clear uncorrectable status");

  a_cor_w1c_clear: assert property (s_cor_clean_write |=>
    (cor_if.val & $past(cfg_wdata)) == 0)
    else $error("write one did not clear correctable status");

  a_sticky_plat_rst: assert property (
    rst && !(cfg_wr && cfg_addr == AER_OFS_UNC_STS) |=>
    (unc_if.val & $past(unc_if.val)) == $past(unc_if.val))
    else $error("uncorrectable status lost on platform reset");

  a_mask_power_sticky: assert property (s_plat_rst_quiet |=>
    $stable(unc_msk_reg) && $stable(unc_sev_reg) && $stable(cor_msk_reg))
    else $error("mask or severity lost on platform reset");

  a_unc_pulse_logs: assert property (s_unc_pulse |=>
    (~unc_if.val & $past(unc_err_pulse & AER_UNC_IMPL)) == 0)
    else $error("uncorrectable event not logged");

  a_cor_pulse_logs: assert property (s_cor_pulse |=>
    (~cor_if.val & $past(cor_err_pulse & AER_COR_IMPL) & ~(32'h0000_0001 << AER_COR_ANF_BIT)) == 0)
    else $error("correctable event not logged");

  a_ct_needs_enable: assert property (!cpl_timeout_en && !adv_nonfatal_pulse &&
    !unc_if.val[AER_UNC_CT_BIT] |=> !unc_if.val[AER_UNC_CT_BIT])
    else $error("completion timeout set while checking disabled");

  a_ct_enabled_logs: assert property (
    cpl_timeout_en && unc_err_pulse[AER_UNC_CT_BIT] |=> unc_if.val[AER_UNC_CT_BIT])
    else $error("completion timeout not logged while enabled");

  a_unsup_bits_zero: assert property ((unc_if.val & ~AER_UNC_IMPL) == 0 &&
    (unc_msk_reg & ~AER_UNC_IMPL) == 0 &&
    (unc_sev_reg & ~AER_UNC_IMPL & ~AER_UNC_SEV_FIXED) == 0)
    else $error("unsupported uncorrectable bit became set");

  a_cor_unsup_zero: assert property ((cor_if.val & ~AER_COR_IMPL) == 0 &&
    (cor_msk_reg & ~AER_COR_IMPL) == 0)
    else $error("reserved correctable bit became set");

  a_fatal_class: assert property (disable iff (pwr_rst || rst)
    (unc_live & unc_sev_view) != 0 |=> unc_fatal_evt)
    else $error("fatal error not signalled");

  a_nonfatal_class: assert property (disable iff (pwr_rst || rst)
    (unc_live & ~unc_sev_view) != 0 |=> unc_nonfatal_evt)
    else $error("non-fatal error not signalled");

  a_masked_silent: assert property (disable iff (pwr_rst || rst)
    unc_live == 0 |=> !unc_fatal_evt && !unc_nonfatal_evt)
    else $error("masked uncorrectable error signalled");

  a_cor_masked_silent: assert property (disable iff (pwr_rst || rst)
    (cor_set & ~cor_msk_reg) == 0 |=> !cor_err_evt)
    else $error("masked correctable error signalled");

  a_train_sev_one: assert property (unc_sev_view[0] == 1'b1)
    else $error("training error severity not one");

  a_anf_logs: assert property (adv_nonfatal_pulse |=> cor_if.val[AER_COR_ANF_BIT])
    else $error("advisory error not logged");

  a_anf_blocked: assert property (disable iff (pwr_rst || rst)
    anf_blocked && adv_nonfatal_pulse && (cor_err_pulse & ~cor_msk_reg & AER_COR_IMPL) == 0
    |=> !cor_err_evt)
    else $error("masked advisory error signalled");

  a_anf_unc_blocked: assert property (anf_blocked && adv_nonfatal_pulse &&
    unc_err_pulse == 0 && !cfg_wr |=> $stable(unc_if.val))
    else $error("masked advisory error updated uncorrectable status");

  a_fep_first_only: assert property (unc_if.val != 0 && unc_live != 0 |=>
    $stable(first_error_pointer_reg))
    else $error("first error pointer overwritten");

  a_fep_load: assert property (unc_if.val == 0 && unc_live != 0 |=>
    first_error_pointer_reg == lowest_bit($past(unc_live)) ##0 unc_if.val != 0)
    else $error("first error pointer not loaded");

  a_hdr_write_once: assert property (s_hdr_locked_write |=>
    $stable(next_capability_pointer_reg) && $stable(capability_version_field_reg) &&
    $stable(capability_identifier_field_reg))
    else $error("capability header rewritten");

  a_hdr_first_load: assert property (
    !hdr_written_reg && cfg_wr && cfg_addr == AER_OFS_HDR |=>
    next_capability_pointer_reg == $past(cfg_wdata[AER_NXT_LSB +: AER_NXT_W]))
    else $error("next capability pointer not loaded by first write");

  a_read_reserved: assert property (disable iff (pwr_rst || rst)
    cfg_rd && cfg_addr == AER_OFS_CAP_CTL |=> cfg_rvalid && cfg_rdata[31:5] == 0)
    else $error("reserved capability bits read nonzero");

  a_read_unmapped: assert property (disable iff (pwr_rst || rst)
    cfg_rd && (cfg_addr < AER_OFS_HDR || cfg_addr > AER_OFS_CAP_CTL || cfg_addr[1:0] != 2'h0)
    |=> cfg_rvalid && cfg_rdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");
endmodule
`default_nettype wire

//--- verification/aer_err_src.sv
// Partner model: link and transaction layer error reports toward the root port
`timescale 1ns/1ps
`default_nettype none
module aer_err_src (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fire,
  input wire logic [31:0] unc_in,
  input wire logic [31:0] cor_in,
  input wire logic adv_in,
  input wire logic [4:0] pos_in,
  output logic [31:0] unc_err_pulse,
  output logic [31:0] cor_err_pulse,
  output logic adv_nonfatal_pulse,
  output logic [4:0] adv_unc_pos
);
  // ==========================================================================
  // One-cycle reports, idle low; the position line toggles while unused
  always_ff @(posedge clk_sys) begin
    unc_err_pulse <= fire ? unc_in : 32'h0;
    cor_err_pulse <= fire ? cor_in : 32'h0;
    adv_nonfatal_pulse <= fire & adv_in;
    adv_unc_pos <= rst ? 5'h0 : (fire ? pos_in : ~adv_unc_pos);
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the error logging register set
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aer_pkg::*;
  logic clk_sys, rst, pwr_rst, cfg_rd, cfg_wr, cpl_timeout_en, s_fire, s_adv;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, s_unc, s_cor, cfg_rdata, unc_err_pulse, cor_err_pulse;
  logic [4:0] s_pos, adv_unc_pos;
  logic cfg_rvalid, adv_nonfatal_pulse, unc_fatal_evt, unc_nonfatal_evt, cor_err_evt;
  logic [31:0] hdr, us, um, uv, cs, cm;
  logic [4:0] fp;
  logic hd, ef, en, ec;
  logic [11:0] ro_addr [6] = '{12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118};
  int err_total = 0;
  int checks = 0;
  int seed = 85236;
  // ==========================================================================
  // Design and error source
  aer_err_log i_dut (
    .clk_sys(clk_sys), .rst(rst), .pwr_rst(pwr_rst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .unc_err_pulse(unc_err_pulse), .cpl_timeout_en(cpl_timeout_en),
    .cor_err_pulse(cor_err_pulse), .adv_nonfatal_pulse(adv_nonfatal_pulse),
    .adv_unc_pos(adv_unc_pos), .unc_fatal_evt(unc_fatal_evt),
    .unc_nonfatal_evt(unc_nonfatal_evt), .cor_err_evt(cor_err_evt)
  );
  aer_err_src i_src (
    .clk_sys(clk_sys), .rst(pwr_rst), .fire(s_fire), .unc_in(s_unc), .cor_in(s_cor),
    .adv_in(s_adv), .pos_in(s_pos), .unc_err_pulse(unc_err_pulse),
    .cor_err_pulse(cor_err_pulse), .adv_nonfatal_pulse(adv_nonfatal_pulse),
    .adv_unc_pos(adv_unc_pos)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Reference model
  task automatic m_init();
    {hdr, us, um, cs, hd, fp} = '0;
    uv = 32'h0006_0011;
    cm = 32'h0000_2000;
  endtask
  function automatic logic [31:0] m_rd(input logic [11:0] a);
    case (a)
      12'h100: return hdr;
      12'h104: return us;
      12'h108: return um;
      12'h10C: return uv;
      12'h110: return cs;
      12'h114: return cm;
      12'h118: return {27'h0, fp};
      default: return 32'h0;
    endcase
  endfunction
  task automatic m_wr(input logic [11:0] a, input logic [31:0] d);
    case (a)
      12'h100: begin
        if (!hd) hdr = d;
        hd = 1'b1;
      end
      12'h104: us = us & ~d;
      12'h108: um = d & AER_UNC_IMPL;
      12'h10C: uv = (d & AER_UNC_IMPL) | 32'h1;
      12'h110: cs = cs & ~d;
      12'h114: cm = d & AER_COR_IMPL;
      default: ;
    endcase
  endtask
  task automatic m_ev(input logic [31:0] u, c, input logic a, input logic [4:0] p,
                      input logic te);
    logic [31:0] ue;
    logic [31:0] ce;
    ue = u & AER_UNC_IMPL;
    if (!te) ue[14] = 1'b0;
    ce = c & AER_COR_IMPL & ~32'h2000;
    ce[13] = a;
    if (a && !cm[13]) ue = ue | (AER_UNC_IMPL & (32'h1 << p));
    ef = |(ue & ~um & uv);
    en = |(ue & ~um & ~uv);
    ec = |(ce & ~cm);
    if (us == 32'h0) for (int i = 31; i >= 0; i--) if (ue[i] && !um[i]) fp = 5'(i);
    us = us | ue;
    cs = cs | ce;
  endtask
  // ==========================================================================
  // Bus cycles, reports and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    chk({31'h0, cfg_rvalid}, 32'h1);
    chk(cfg_rdata, m_rd(a));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_fire <= 1'b0;
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    m_wr(a, d);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i));
  endtask
  task automatic go(input logic [31:0] u, c, input logic a, input logic [4:0] p,
                    input logic te);
    logic [2:0] seen;
    @(posedge clk_sys);
    {s_unc, s_cor, s_adv, s_pos, s_fire} <= {u, c, a, p, 1'b1};
    cpl_timeout_en <= te;
    @(posedge clk_sys);
    s_fire <= 1'b0;
    @(posedge clk_sys);
    m_ev(u, c, a, p, te);
    #1;
    seen = {unc_fatal_evt, unc_nonfatal_evt, cor_err_evt};
    chk({29'h0, seen}, {29'h0, ef, en, ec});
  endtask
  task automatic give_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    logic [31:0] r;
    {rst, pwr_rst} = 2'h3;
    {cfg_rd, cfg_wr, cpl_timeout_en, s_fire, s_adv} = 5'h0;
    {cfg_addr, cfg_wdata, s_unc, s_cor, s_pos} = '0;
    m_init();
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    pwr_rst <= 1'b0;
    rd_all();
    wr(12'h100, 32'h0001_0001);
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100);
    foreach (ro_addr[i]) begin
      wr(ro_addr[i], 32'hFFFF_FFFF);
      rd(ro_addr[i]);
      wr(ro_addr[i], 32'h0);
      rd(ro_addr[i]);
    end
    wr(12'h10C, 32'h0006_0011);
    wr(12'h114, 32'h0000_2000);
    for (int i = 0; i < 32; i++) begin
      go(32'h1 << i, 32'h0, 1'b0, 5'h0, i != 14);
      rd(12'h104);
      rd(12'h118);
      wr(12'h104, 32'hFFFF_FFFF);
    end
    go(32'h0000_4000, 32'h0, 1'b0, 5'h0, 1'b1);
    rd(12'h104);
    for (int i = 0; i < 32; i++) begin
      go(32'h0, 32'h1 << i, 1'b0, 5'h0, 1'b1);
      rd(12'h110);
    end
    wr(12'h108, 32'h0004_0010);
    go(32'h0004_0010, 32'h0, 1'b0, 5'h0, 1'b1);
    go(32'h0, 32'h0, 1'b1, 5'd12, 1'b1);
    rd(12'h104);
    wr(12'h114, 32'h0);
    go(32'h0, 32'h0, 1'b1, 5'd12, 1'b1);
    rd(12'h104);
    rd(12'h110);
    go(32'h0, 32'h1, 1'b0, 5'h0, 1'b1);
    @(posedge clk_sys);
    {s_unc, s_cor, s_adv, s_fire} <= {32'h0, 32'h80, 1'b0, 1'b1};
    wr(12'h110, 32'h81);
    m_ev(32'h0, 32'h80, 1'b0, 5'h0, 1'b1);
    rd(12'h110);
    for (int n = 0; n < 200; n++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: go($random(seed), $random(seed), 1'b0, 5'h0, r[2]);
        2'h1: wr(12'h100 + {7'h0, r[5:3], 2'h0}, $random(seed));
        default: rd(12'h100 + {7'h0, r[5:3], 2'h0});
      endcase
    end
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_all();
    @(posedge clk_sys);
    pwr_rst <= 1'b1;
    @(posedge clk_sys);
    pwr_rst <= 1'b0;
    m_init();
    rd_all();
    give_verdict();
  end
endmodule
`default_nettype wire
